// >>> src/scss_pkg.sv
// Package for the system clock source select block
package scss_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // ---------------------------------------------------------------
    // Control field positions
    // ---------------------------------------------------------------
    localparam int BIT_PRECISE_ON  = 7;
    localparam int BIT_WDOG_ON     = 5;
    localparam int BIT_PRI_FD_ON   = 4;
    localparam int BIT_WDOG_FD_ON  = 3;
    localparam int SEL_LSB         = 0;
    localparam int SEL_MSB         = 2;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    localparam logic [7:0] CTRL_RESET = 8'ha0;

    // ---------------------------------------------------------------
    // Status field positions
    // ---------------------------------------------------------------
    localparam int ST_PRI_FAIL   = 0;
    localparam int ST_WDOG_FAIL  = 1;
    localparam int ST_RECOVERED  = 2;
    localparam int ST_SRC_LSB    = 4;
    localparam int ST_SRC_MSB    = 6;

    // ---------------------------------------------------------------
    // Source codes
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        SCSS_SRC_PRECISE_FAST = 3'h0,
        SCSS_SRC_PRECISE_SLOW = 3'h1,
        SCSS_SRC_RSVD2        = 3'h2,
        SCSS_SRC_WDOG         = 3'h3,
        SCSS_SRC_EXT_PIN      = 3'h4,
        SCSS_SRC_RSVD5        = 3'h5,
        SCSS_SRC_RSVD6        = 3'h6,
        SCSS_SRC_RSVD7        = 3'h7
    } scss_src_t;

    localparam int FAIL_WINDOW_DEF = 64;
    localparam logic [2:0] SYNC_RESET = 3'h0;
endpackage

// >>> src/scss_activity_mon.sv
// Oscillator activity monitor: synchroniser plus missing-edge timer
`timescale 1ns/1ns
module scss_activity_mon #(
    parameter int WINDOW = scss_pkg::FAIL_WINDOW_DEF
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic osc_in,
    output logic      fail
);
    typedef struct packed {
        logic [2:0]  sync;
        logic [15:0] cnt;
        logic        fail;
    } scss_mon_t;

    scss_mon_t s_q;
    scss_mon_t s_d;

    assign fail = s_q.fail;

    always_comb
    begin
        s_d      = s_q;
        s_d.sync = {s_q.sync[1:0], osc_in};
        if (!enable)
        begin
            // Disabled monitor holds no stale verdict
            s_d.cnt  = 16'h0000;
            s_d.fail = 1'b0;
        end
        else if (s_q.sync[2] != s_q.sync[1])
        begin
            s_d.cnt  = 16'h0000;
            s_d.fail = 1'b0;
        end
        else if (s_q.cnt == 16'(WINDOW - 1))
        begin
            s_d.fail = 1'b1;
        end
        else
        begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end
endmodule

// >>> src/scss_top.sv
// System clock source select: control register, oscillator enables, failover
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// (R1) Precise oscillator runs when its enable set
// (R2) Watchdog oscillator runs when its enable set
// (R3) Primary failure detect and recovery when enabled
// (R4) Watchdog oscillator failure detect when enabled
// (R5) Codes 000/001 pick precise oscillator fast/slow
// (R6) Code 011 picks the watchdog oscillator
// (R7) Code 100 picks the external clock pin
// (R8) Reserved bits written as zero, read zero
// (R9) Software avoids reserved selector codes
module scss_top #(
    parameter int FAIL_WINDOW = scss_pkg::FAIL_WINDOW_DEF
) (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       precise_osc_clk,
    input  wire logic       wdog_osc_clk,
    input  wire logic       ext_clock_input_pin,
    output logic            precise_osc_run,
    output logic            precise_osc_slow,
    output logic            wdog_osc_run,
    output logic      [2:0] sysclk_mux_sel,
    output logic            primary_fail,
    output logic            wdog_osc_fail
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [2:0] src;
        logic       pri_fail;
        logic       wdog_fail;
        logic       recovered;
        logic [7:0] rdata;
        logic       precise_run;
        logic       precise_slow;
        logic       wdog_run;
        logic [1:0] prec_sync;
        logic [1:0] pin_sync;
    } scss_state_t;

    scss_state_t s_q;
    scss_state_t s_d;

    logic       pri_fd_on;
    logic       wdog_fd_on;
    logic       pri_mon_fail;
    logic       wdog_mon_fail;
    logic       pri_is_ext;
    logic       ctrl_wr;
    logic       rd_ctrl;
    logic       rd_status;
    logic [7:0] status_word;

    assign pri_fd_on  = s_q.ctrl[scss_pkg::BIT_PRI_FD_ON];
    assign wdog_fd_on = s_q.ctrl[scss_pkg::BIT_WDOG_FD_ON];
    assign pri_is_ext = (s_q.src == scss_pkg::SCSS_SRC_EXT_PIN);

    // ---------------------------------------------------------------
    // Register decode
    // ---------------------------------------------------------------
    // Other addresses are ignored on write and read as zero
    assign ctrl_wr   = wr && addr == scss_pkg::ADDR_CTRL;
    assign rd_ctrl   = rd && addr == scss_pkg::ADDR_CTRL;
    assign rd_status = rd && addr == scss_pkg::ADDR_STATUS;

    // ---------------------------------------------------------------
    // Status word
    // ---------------------------------------------------------------
    function automatic logic [7:0] pack_status(input scss_state_t st);
        logic [7:0] w;
        w = 8'h00; // R8
        w[scss_pkg::ST_PRI_FAIL]  = st.pri_fail;
        w[scss_pkg::ST_WDOG_FAIL] = st.wdog_fail;
        w[scss_pkg::ST_RECOVERED] = st.recovered;
        w[scss_pkg::ST_SRC_MSB:scss_pkg::ST_SRC_LSB] = st.src;
        return w;
    endfunction

    assign status_word = pack_status(s_q);

    // ---------------------------------------------------------------
    // Source decode
    // ---------------------------------------------------------------
    // Reserved codes keep the last legal source, so a stray write
    // never parks the system clock on an undefined input
    function automatic logic [2:0] pick_src(
        input logic [2:0] code,
        input logic [2:0] keep
    );
        logic [2:0] pick;
        case (code)
            scss_pkg::SCSS_SRC_PRECISE_FAST: pick = scss_pkg::SCSS_SRC_PRECISE_FAST; // R5
            scss_pkg::SCSS_SRC_PRECISE_SLOW: pick = scss_pkg::SCSS_SRC_PRECISE_SLOW; // R5
            scss_pkg::SCSS_SRC_WDOG:         pick = scss_pkg::SCSS_SRC_WDOG; // R6
            scss_pkg::SCSS_SRC_EXT_PIN:      pick = scss_pkg::SCSS_SRC_EXT_PIN; // R7
            default:                         pick = keep; // R9
        endcase
        return pick;
    endfunction

    // ---------------------------------------------------------------
    // Monitors
    // ---------------------------------------------------------------
    // Primary is whichever non-watchdog source is selected
    localparam int MON_PRI  = 0;
    localparam int MON_WDOG = 1;
    localparam int MON_NUM  = 2;

    logic [MON_NUM-1:0] mon_en;
    logic [MON_NUM-1:0] mon_osc;
    logic [MON_NUM-1:0] mon_fail;

    assign mon_en[MON_PRI]   = pri_fd_on && s_q.src != scss_pkg::SCSS_SRC_WDOG
                               && !s_q.recovered; // R3
    // Both primary candidates are synchronised ahead of the mux
    assign mon_osc[MON_PRI]  = pri_is_ext ? s_q.pin_sync[1] : s_q.prec_sync[1];
    assign mon_en[MON_WDOG]  = wdog_fd_on && s_q.wdog_run; // R4
    assign mon_osc[MON_WDOG] = wdog_osc_clk;
    assign pri_mon_fail      = mon_fail[MON_PRI];
    assign wdog_mon_fail     = mon_fail[MON_WDOG];

    generate
        for (genvar g = 0; g < MON_NUM; g++)
        begin
            scss_activity_mon #(.WINDOW(FAIL_WINDOW)) u_mon (
                .mclk   (mclk),
                .srst   (srst),
                .ce     (ce),
                .enable (mon_en[g]),
                .osc_in (mon_osc[g]),
                .fail   (mon_fail[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = 8'h00;
        // Two flops ahead of the primary mux; the monitor adds its own
        s_d.prec_sync = {s_q.prec_sync[0], precise_osc_clk};
        s_d.pin_sync  = {s_q.pin_sync[0], ext_clock_input_pin};

        if (ctrl_wr)
        begin
            s_d.ctrl      = wdata & scss_pkg::CTRL_WMASK; // R8
            s_d.recovered = 1'b0;
            s_d.pri_fail  = 1'b0;
        end

        // Source follows selector unless a recovery overrides it
        if (!s_d.recovered)
        begin
            s_d.src = pick_src(s_d.ctrl[scss_pkg::SEL_MSB:scss_pkg::SEL_LSB], s_q.src);
        end

        if (pri_mon_fail && pri_fd_on)
        begin
            // Fall back to the watchdog oscillator, forcing it on
            s_d.pri_fail  = 1'b1; // R3
            s_d.recovered = 1'b1;
            s_d.src       = scss_pkg::SCSS_SRC_WDOG;
        end

        // Dropping detection ends any recovery at once
        if (!s_d.ctrl[scss_pkg::BIT_PRI_FD_ON])
        begin
            s_d.pri_fail  = 1'b0; // R3
            s_d.recovered = 1'b0;
        end

        s_d.wdog_fail = wdog_mon_fail && wdog_fd_on; // R4
        s_d.precise_run = s_d.ctrl[scss_pkg::BIT_PRECISE_ON]; // R1
        s_d.precise_slow = (s_d.src == scss_pkg::SCSS_SRC_PRECISE_SLOW);
        s_d.wdog_run = s_d.ctrl[scss_pkg::BIT_WDOG_ON] || s_d.recovered; // R2

        if (rd_ctrl)
        begin
            s_d.rdata = s_q.ctrl; // R8
        end
        else if (rd_status)
        begin
            s_d.rdata = status_word;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            // Both oscillators run out of reset, matching the control default
            s_q              <= '0;
            s_q.ctrl         <= scss_pkg::CTRL_RESET;
            s_q.precise_run  <= 1'b1;
            s_q.wdog_run     <= 1'b1;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign rdata            = s_q.rdata;
    assign precise_osc_run  = s_q.precise_run;
    assign precise_osc_slow = s_q.precise_slow;
    assign wdog_osc_run     = s_q.wdog_run;
    assign sysclk_mux_sel   = s_q.src;
    assign primary_fail     = s_q.pri_fail;
    assign wdog_osc_fail    = s_q.wdog_fail;
endmodule

// >>> sim/scss_osc_model.sv
// Oscillator and clock pin model
`timescale 1ns/1ns
module scss_osc_model (
    input  wire logic precise_osc_run,
    input  wire logic wdog_osc_run,
    input  wire logic stop_pri,
    input  wire logic stop_wdog,
    output logic      precise_osc_clk,
    output logic      wdog_osc_clk,
    output logic      ext_clk
);
    initial {precise_osc_clk, wdog_osc_clk, ext_clk} = 3'h0;
    // A dead oscillator freezes at its level
    always #130 if (precise_osc_run && !stop_pri) precise_osc_clk = !precise_osc_clk;
    always #350 if (wdog_osc_run && !stop_wdog) wdog_osc_clk = !wdog_osc_clk;
    always #170 ext_clk = !ext_clk;
endmodule

// >>> sim/scss_assertions.sv
// Port checker for the clock source select block
`timescale 1ns/1ns
module scss_assertions (
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       precise_osc_run,
    input wire logic       precise_osc_slow,
    input wire logic       wdog_osc_run,
    input wire logic [2:0] sysclk_mux_sel,
    input wire logic       primary_fail,
    input wire logic       wdog_osc_fail
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !ce);
    wire wc = ce && wr && addr == scss_pkg::ADDR_CTRL && !wdata[4];
    property p_run; wc |=> precise_osc_run == $past(wdata[7]); endproperty
    a_run: assert property (p_run) else $error("precise run wrong");
    property p_wdog; wc |=> wdog_osc_run == $past(wdata[5]); endproperty
    a_wdog: assert property (p_wdog) else $error("wdog run wrong");
    property p_sel; wc && wdata[2:0] inside {0, 1, 3, 4} |=> sysclk_mux_sel == $past(wdata[2:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("source wrong");
    property p_slow; precise_osc_slow == (sysclk_mux_sel == 3'h1); endproperty
    a_slow: assert property (p_slow) else $error("slow flag wrong");
    property p_rsvd; rd && addr == scss_pkg::ADDR_CTRL |=> !rdata[6]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_prioff; wc |-> ##4 !primary_fail; endproperty
    a_prioff: assert property (p_prioff) else $error("primary fail kept");
    property p_recov; $rose(primary_fail) |-> ##[0:2] (sysclk_mux_sel == 3'h3 && wdog_osc_run);
    endproperty
    a_recov: assert property (p_recov) else $error("no recovery");
    property p_wdoff; wc && !wdata[3] ##1 !wr [*4] |-> !wdog_osc_fail; endproperty
    a_wdoff: assert property (p_wdoff) else $error("wdog fail kept");
endmodule
bind scss_top scss_assertions i_chk (.mclk, .srst, .ce, .addr, .wdata, .wr, .rd, .rdata,
    .precise_osc_run, .precise_osc_slow, .wdog_osc_run, .sysclk_mux_sel, .primary_fail,
    .wdog_osc_fail);

// >>> sim/test_system_clock_source_select.sv
// Bench for the clock source select block
`timescale 1ns/1ns
module test_system_clock_source_select;
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       stp = 1'b0;
    logic       stw = 1'b0;
    logic       ce = 1'b1;
    logic [7:0] rdata, d;
    logic [2:0] sel, cur;
    logic       pc, wc, xc, pr, ps, wrn, pf, wf;
    int         err_total = 0;
    int         tests_run = 0;
    int         cyc = 0;
    always #50 mclk = !mclk;
    scss_top #(.FAIL_WINDOW(8)) i_dut (.mclk, .srst, .ce, .addr, .wdata, .wr, .rd,
        .rdata, .precise_osc_clk(pc), .wdog_osc_clk(wc), .ext_clock_input_pin(xc),
        .precise_osc_run(pr), .precise_osc_slow(ps), .wdog_osc_run(wrn),
        .sysclk_mux_sel(sel), .primary_fail(pf), .wdog_osc_fail(wf));
    scss_osc_model i_osc (.precise_osc_run(pr), .wdog_osc_run(wrn), .stop_pri(stp),
        .stop_wdog(stw), .precise_osc_clk(pc), .wdog_osc_clk(wc), .ext_clk(xc));
    function automatic logic [2:0] exp_src(input logic [2:0] p, input logic [2:0] c);
        return (c == 3'h2 || c > 3'h4) ? p : c;
    endfunction
    // Software only ever programs the four legal selector codes
    function automatic logic [2:0] legal_sel(input logic [2:0] c);
        return (c == 3'h2) ? 3'h3 : ((c > 3'h4) ? 3'h4 : c);
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic acc(input logic [3:0] a, input logic [7:0] v, input logic w);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        d = 8'($urandom(32'hcbe2));
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        acc(4'h0, 8'h00, 1'b0);
        chk(rdata, scss_pkg::CTRL_RESET);
        chk({pr, wrn, 3'h0, sel}, 8'hc0);
        cur = 3'h0;
        for (int i = 0; i < 40; i++)
        begin
            d = 8'($urandom);
            d[6] = 1'b0;
            d[4:3] = 2'b00;
            if (i < 5)
                d[2:0] = 3'(i);
            d[2:0] = legal_sel(d[2:0]);
            acc(4'h0, d, 1'b1);
            cur = exp_src(cur, d[2:0]);
            chk({pr, wrn, ps, 2'h0, sel}, {d[7], d[5], cur == 3'h1, 2'h0, cur});
            acc(4'h0, 8'h00, 1'b0);
            chk(rdata, d & 8'hbf);
        end
        acc(4'h4, 8'h00, 1'b0);
        chk(rdata, {1'b0, cur, 4'h0});
        acc(4'h8, 8'h00, 1'b0);
        chk(rdata, 8'h00);
        acc(4'h0, 8'hb0, 1'b1);
        stp <= 1'b1;
        for (int i = 0; i < 200 && pf !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk({pf, wrn, 3'h0, sel}, 8'hc3);
        acc(4'h4, 8'h00, 1'b0);
        chk(rdata, 8'h35);
        acc(4'h0, 8'ha0, 1'b1);
        repeat (40) @(posedge mclk);
        #1;
        chk({pf, 4'h0, sel}, 8'h00);
        stp <= 1'b0;
        acc(4'h0, 8'ha8, 1'b1);
        stw <= 1'b1;
        for (int i = 0; i < 200 && wf !== 1'b1; i++)
        begin
            @(posedge mclk);
            #1;
        end
        chk({7'h0, wf}, 8'h01);
        acc(4'h0, 8'ha0, 1'b1);
        repeat (4) @(posedge mclk);
        #1;
        chk({7'h0, wf}, 8'h00);
        // Clock enable low: the write is lost and every output holds
        @(posedge mclk);
        ce <= 1'b0;
        acc(4'h0, 8'h83, 1'b1);
        chk({pr, wrn, 3'h0, sel}, 8'hc0);
        @(posedge mclk);
        ce <= 1'b1;
        acc(4'h0, 8'h00, 1'b0);
        chk(rdata, 8'ha0);
        finish_test;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            finish_test;
        end
    end
endmodule
